// [core/flb_defs.svh]
// flash service constants: register offsets, codes, keys, reset values
// assumes a 12-bit byte address on the register bus, one word per register
// Operation
// RULE_01: program moves exactly 64 bytes per call
// RULE_02: caller erases the block before programming
// RULE_03: protected program returns acc 0, keys 01/00
// RULE_04: only the external programmer changes protection
// RULE_05: caller gives block number 00h to 7Fh
// RULE_06: source page comes from indirect read page
// RULE_07: caller gives first source byte address
// RULE_08: divider value sets the program pulse width
// RULE_09: caller sets delay by cpu speed
// RULE_10: caller sets key bytes 3Ah and sp+3
// RULE_11: code 02h programs, code 03h erases
// RULE_12: erase clears one 64-byte block
// RULE_13: protected erase returns acc 0, keys 01/00
// RULE_14: divider value sets the erase pulse width
// RULE_15: two-bit protection mode per block
// RULE_16: indexed rom reads ignore protection
// RULE_17: bulk erase wipes data and protection
// RULE_18: bulk erase from firmware halts, changes nothing
// RULE_19: factory tables readable only through the service
// RULE_20: factory table read also returns revision
// RULE_21: table 3 holds cold and hot constants
// RULE_22: bad key bytes halt until reset
// RULE_23: refused operation leaves block untouched
// RULE_24: key, protection, fetch, pulse, then status
`ifndef FLB_DEFS_SVH
`define FLB_DEFS_SVH
`define FLB_OFF_FUNC 12'h000
`define FLB_OFF_FKEY 12'h004
`define FLB_OFF_SKEY 12'h008
`define FLB_OFF_BLOCK 12'h00C
`define FLB_OFF_PTR 12'h010
`define FLB_OFF_CLKDIV 12'h014
`define FLB_OFF_DELAY 12'h018
`define FLB_OFF_PAGE 12'h01C
`define FLB_OFF_ACC 12'h020
`define FLB_OFF_STATUS 12'h024
`define FLB_OFF_ROMADDR 12'h028
`define FLB_OFF_ROMDATA 12'h02C
`define FLB_OFF_TBLSEL 12'h030
`define FLB_OFF_TDLO 12'h034
`define FLB_OFF_TDHI 12'h038
`define FLB_OFF_REV 12'h03C
`define FLB_OFF_PROT 12'h040
`define FLB_SRAM_BIT 11
`define FLB_FN_PROGRAM 8'h02
`define FLB_FN_ERASE 8'h03
`define FLB_FN_BULK 8'h05
`define FLB_FN_TABLE 8'h06
`define FLB_FKEY_VAL 8'h3A
`define FLB_SKEY_ADD 8'h03
`define FLB_RET_OK 8'h00
`define FLB_RET_FAIL 8'h01
`define FLB_BLK_BYTES 64
`define FLB_LAST_BYTE 6'h3F
`define FLB_MODE_OPEN 2'h0
`define FLB_MODE_RDPROT 2'h1
`define FLB_MODE_NO_EXTW 2'h2
`define FLB_MODE_NO_INTW 2'h3
`define FLB_ERASED 8'hFF
`define FLB_FLASH_AW 13
`define FLB_SRAM_AW 9
`define FLB_RST_BYTE 8'h00
`endif

// [core/flb_pkg.sv]
// types shared by the flash service modules
// constants live in flb_defs.svh
package flb_pkg;
    // gray codes along idle, key, protect, fetch, pulse, done
    typedef enum logic [2:0] {
        FLB_IDLE = 3'h0,
        FLB_KEY = 3'h1,
        FLB_PROT = 3'h3,
        FLB_FETCH = 3'h2,
        FLB_PULSE = 3'h6,
        FLB_DONE = 3'h7,
        FLB_HALT = 3'h5,
        FLB_TABLE = 3'h4
    } flb_state_t;

    typedef struct packed {
        flb_state_t state;
        logic [7:0] func;
        logic [7:0] sp;
        logic [7:0] fkey;
        logic [7:0] skey;
        logic [7:0] blk;
        logic [7:0] ptr;
        logic [7:0] clk_div;
        logic [7:0] delay;
        logic [7:0] page;
        logic [7:0] acc;
        logic fail;
        logic [5:0] idx;
        logic [7:0] div_cnt;
        logic [7:0] pulse_cnt;
        logic [12:0] rom_addr;
        logic [1:0] tbl;
        logic [63:0] tdata;
        logic [7:0] rev;
        logic [31:0] prdata;
    } flb_regs_t;
endpackage : flb_pkg

// [core/flb_if.sv]
// carriers between the service core, the flash array and the sram
// both ends run on pclk
`timescale 1ns/1ps
`include "flb_defs.svh"
interface flb_flash_if;
    logic [`FLB_FLASH_AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    logic blk_erase;
    logic bulk_erase;
    logic [6:0] blk;
    logic [1:0] mode;
    logic prot_wr;
    logic [6:0] prot_blk;
    logic [1:0] prot_val;
    logic [1:0] tbl;
    logic [63:0] tdata;
    logic [7:0] rev;
    modport core (output addr, wdata, wr, blk_erase, bulk_erase, blk,
        prot_wr, prot_blk, prot_val, tbl,
        input rdata, mode, tdata, rev);
    modport mem (input addr, wdata, wr, blk_erase, bulk_erase, blk,
        prot_wr, prot_blk, prot_val, tbl,
        output rdata, mode, tdata, rev);
endinterface : flb_flash_if

interface flb_sram_if;
    logic we;
    logic [`FLB_SRAM_AW-1:0] waddr;
    logic [7:0] wdata;
    logic [`FLB_SRAM_AW-1:0] raddr_a;
    logic [7:0] rdata_a;
    logic [`FLB_SRAM_AW-1:0] raddr_b;
    logic [7:0] rdata_b;
    modport core (output we, waddr, wdata, raddr_a, raddr_b,
        input rdata_a, rdata_b);
    modport mem (input we, waddr, wdata, raddr_a, raddr_b,
        output rdata_a, rdata_b);
endinterface : flb_sram_if

// [core/flb_sram.sv]
// byte sram holding the caller's source buffers
// written over the register bus, read by bus and by the sequencer
`timescale 1ns/1ps
`include "flb_defs.svh"
module flb_sram #(
    parameter int DEPTH = 512
) (
    input wire logic pclk,
    flb_sram_if.mem sif
);
    logic [7:0] mem [0:DEPTH-1];

    // no reset: contents are undefined until software fills them
    always_ff @(posedge pclk)
    begin
        if (sif.we)
        begin
            mem[sif.waddr] <= sif.wdata;
        end
    end

    // two combinational read ports so a bus read never stalls a fetch
    assign sif.rdata_a = mem[sif.raddr_a];
    assign sif.rdata_b = mem[sif.raddr_b];
endmodule : flb_sram

// [core/flb_flash.sv]
// flash array model with per-block protection and factory tables
// driven only by flb_core; protection survives until bulk erase or presetn
`timescale 1ns/1ps
`include "flb_defs.svh"
module flb_flash #(
    parameter int BLOCKS = 128,
    parameter logic [63:0] TBL0 = 64'h0000000000000011,
    parameter logic [63:0] TBL1 = 64'h0000000000000000,
    parameter logic [63:0] TBL2 = 64'h0000000000000000,
    parameter logic [47:0] TBL3_CONST = 48'h000000000000,
    parameter logic [7:0] REV_ID = 8'h5A // arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,
    flb_flash_if.mem fif
);
    logic [7:0] mem [0:BLOCKS*`FLB_BLK_BYTES-1];
    logic [1:0] prot [0:BLOCKS-1];

    // programming can only clear bits, so the block must be erased first
    always_ff @(posedge pclk)
    begin
        if (fif.bulk_erase)
        begin
            for (int i = 0; i < BLOCKS*`FLB_BLK_BYTES; i++)
                mem[i] <= `FLB_ERASED; // RULE_17
        end
        else if (fif.blk_erase)
        begin
            for (int i = 0; i < `FLB_BLK_BYTES; i++)
                mem[{fif.blk, 6'(i)}] <= `FLB_ERASED; // RULE_12
        end
        else if (fif.wr)
        begin
            mem[fif.addr] <= mem[fif.addr] & fif.wdata; // RULE_02
        end
    end

    // protection modes; reset stands in for a blank part
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < BLOCKS; i++)
                prot[i] <= `FLB_MODE_OPEN;
        end
        else if (fif.bulk_erase)
        begin
            for (int i = 0; i < BLOCKS; i++)
                prot[i] <= `FLB_MODE_OPEN; // RULE_17
        end
        else if (fif.prot_wr)
        begin
            prot[fif.prot_blk] <= fif.prot_val; // RULE_15
        end
    end

    assign fif.rdata = mem[fif.addr];
    assign fif.mode = prot[fif.blk];
    assign fif.rev = REV_ID; // RULE_20

    // tables sit outside the program array; byte F8h in the low lane
    always_comb
    begin
        case (fif.tbl)
            2'h0: fif.tdata = TBL0;
            2'h1: fif.tdata = TBL1;
            2'h2: fif.tdata = TBL2;
            default: fif.tdata = {8'h01, 8'h00, TBL3_CONST}; // RULE_21
        endcase
    end
endmodule : flb_flash

// [core/flb_core.sv]
// flash service sequencer with apb register slave
// assumes an external-programmer strap input and a 10 MHz pclk
`timescale 1ns/1ps
`include "flb_defs.svh"
module flb_core #(
    parameter int SRAM_DEPTH = 512,
    parameter int BLOCKS = 128
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_prog,
    output logic cpu_halt,
    output logic busy,
    output logic flash_pulse
);
    flb_pkg::flb_regs_t q;
    flb_pkg::flb_regs_t next_q;
    flb_flash_if fif ();
    flb_sram_if sif ();
    logic acc_wr;
    logic setup;
    logic refuse;
    logic tick;
    logic last_tick;
    logic key_ok;
    logic known_fn;

    flb_flash #(.BLOCKS(BLOCKS)) u_flash (
        .pclk(pclk),
        .presetn(presetn),
        .fif(fif)
    );

    flb_sram #(.DEPTH(SRAM_DEPTH)) u_sram (
        .pclk(pclk),
        .sif(sif)
    );

    // every word offset below the sram window that the decoder knows
    function automatic logic flb_mapped(input logic [11:0] a);
        if (a[`FLB_SRAM_BIT])
            return 1'b1;
        else if (a[1:0] != 2'h0)
            return 1'b0;
        else
            return a <= `FLB_OFF_PROT;
    endfunction : flb_mapped

    // refusal by mode: firmware is stopped by 11b, the programmer by 10b
    function automatic logic flb_refused(input logic [1:0] m,
        input logic ext);
        if (ext)
            return m == `FLB_MODE_NO_EXTW;
        else
            return m == `FLB_MODE_NO_INTW;
    endfunction : flb_refused

    // apb handshake: zero wait, read data latched in the setup cycle
    assign setup = psel & ~penable;
    assign pready = psel & penable;
    assign acc_wr = pready & pwrite & flb_mapped(paddr);
    assign pslverr = pready & ~flb_mapped(paddr);
    assign prdata = q.prdata;
    assign cpu_halt = q.state == flb_pkg::FLB_HALT;
    assign busy = q.state != flb_pkg::FLB_IDLE;
    assign flash_pulse = q.state == flb_pkg::FLB_PULSE;

    // flash port: the sequencer owns the address only while fetching
    assign fif.addr = (q.state == flb_pkg::FLB_FETCH) ?
        {q.blk[6:0], q.idx} : q.rom_addr;
    assign fif.blk = q.blk[6:0];
    assign fif.tbl = q.tbl;
    assign fif.wr = q.state == flb_pkg::FLB_FETCH; // RULE_01
    assign fif.wdata = sif.rdata_b;
    assign fif.prot_wr = acc_wr & ext_prog & (paddr == `FLB_OFF_PROT); // RULE_04
    assign fif.prot_blk = pwdata[6:0];
    assign fif.prot_val = pwdata[9:8];
    assign sif.raddr_b = {q.page[0], 8'(q.ptr + {2'h0, q.idx})}; // RULE_06
    assign sif.raddr_a = paddr[10:2];
    assign sif.we = acc_wr & paddr[`FLB_SRAM_BIT];
    assign sif.waddr = paddr[10:2];
    assign sif.wdata = pwdata[7:0];

    // pulse timebase: one tick every delay+1 cycles
    assign tick = q.div_cnt == 8'h00;
    assign last_tick = tick & (q.pulse_cnt <= 8'h01);
    assign fif.blk_erase = flash_pulse & last_tick &
        (q.func == `FLB_FN_ERASE); // RULE_12
    assign fif.bulk_erase = flash_pulse & last_tick &
        (q.func == `FLB_FN_BULK) & ext_prog; // RULE_17
    assign refuse = q.blk[7] | flb_refused(fif.mode, ext_prog); // RULE_05
    assign key_ok = (q.fkey == `FLB_FKEY_VAL) &&
        (q.skey == 8'(q.sp + `FLB_SKEY_ADD)); // RULE_10
    assign known_fn = (q.func == `FLB_FN_PROGRAM) ||
        (q.func == `FLB_FN_ERASE) || (q.func == `FLB_FN_BULK) ||
        (q.func == `FLB_FN_TABLE); // RULE_11

    // next state of the whole block
    always_comb
    begin
        next_q = q;
        if (setup)
        begin
            next_q.prdata = 32'h00000000;
            if (paddr[`FLB_SRAM_BIT])
                next_q.prdata[7:0] = sif.rdata_a;
            else if (paddr == `FLB_OFF_FUNC)
                next_q.prdata[15:0] = {q.sp, q.func};
            else if (paddr == `FLB_OFF_FKEY)
                next_q.prdata[7:0] = q.fkey;
            else if (paddr == `FLB_OFF_SKEY)
                next_q.prdata[7:0] = q.skey;
            else if (paddr == `FLB_OFF_BLOCK)
                next_q.prdata[7:0] = q.blk;
            else if (paddr == `FLB_OFF_PTR)
                next_q.prdata[7:0] = q.ptr;
            else if (paddr == `FLB_OFF_CLKDIV)
                next_q.prdata[7:0] = q.clk_div;
            else if (paddr == `FLB_OFF_DELAY)
                next_q.prdata[7:0] = q.delay;
            else if (paddr == `FLB_OFF_PAGE)
                next_q.prdata[7:0] = q.page;
            else if (paddr == `FLB_OFF_ACC)
                next_q.prdata[7:0] = q.acc;
            else if (paddr == `FLB_OFF_STATUS)
                next_q.prdata[3:0] = {q.fail, ext_prog, cpu_halt, busy};
            else if (paddr == `FLB_OFF_ROMADDR)
                next_q.prdata[12:0] = q.rom_addr;
            else if (paddr == `FLB_OFF_ROMDATA)
                next_q.prdata[7:0] = fif.rdata; // RULE_16
            else if (paddr == `FLB_OFF_TBLSEL)
                next_q.prdata[1:0] = q.tbl;
            else if (paddr == `FLB_OFF_TDLO)
                next_q.prdata = q.tdata[31:0];
            else if (paddr == `FLB_OFF_TDHI)
                next_q.prdata = q.tdata[63:32];
            else if (paddr == `FLB_OFF_REV)
                next_q.prdata[7:0] = q.rev;
            else if (paddr == `FLB_OFF_PROT)
                next_q.prdata[1:0] = fif.mode;
        end
        // parameter block writes; locked while a call runs
        if (acc_wr && !busy)
        begin
            if (paddr == `FLB_OFF_FUNC)
            begin
                next_q.func = pwdata[7:0];
                next_q.sp = pwdata[15:8];
                next_q.state = flb_pkg::FLB_KEY;
            end
            else if (paddr == `FLB_OFF_FKEY)
                next_q.fkey = pwdata[7:0];
            else if (paddr == `FLB_OFF_SKEY)
                next_q.skey = pwdata[7:0];
            else if (paddr == `FLB_OFF_BLOCK)
                next_q.blk = pwdata[7:0];
            else if (paddr == `FLB_OFF_PTR)
                next_q.ptr = pwdata[7:0];
            else if (paddr == `FLB_OFF_CLKDIV)
                next_q.clk_div = pwdata[7:0];
            else if (paddr == `FLB_OFF_DELAY)
                next_q.delay = pwdata[7:0];
            else if (paddr == `FLB_OFF_PAGE)
                next_q.page = pwdata[7:0];
            else if (paddr == `FLB_OFF_ROMADDR)
                next_q.rom_addr = pwdata[12:0];
            else if (paddr == `FLB_OFF_TBLSEL)
                next_q.tbl = pwdata[1:0];
        end
        // service sequence
        case (q.state)
            flb_pkg::FLB_KEY:
            begin
                // a bad key or a firmware bulk erase stops the cpu until reset
                if (!key_ok || !known_fn)
                    next_q.state = flb_pkg::FLB_HALT; // RULE_22
                else if (q.func == `FLB_FN_BULK && !ext_prog)
                    next_q.state = flb_pkg::FLB_HALT; // RULE_18
                else if (q.func == `FLB_FN_TABLE)
                    next_q.state = flb_pkg::FLB_TABLE;
                else if (q.func == `FLB_FN_BULK)
                begin
                    next_q.state = flb_pkg::FLB_PULSE;
                    next_q.div_cnt = q.delay;
                    next_q.pulse_cnt = q.clk_div;
                end
                else
                    next_q.state = flb_pkg::FLB_PROT; // RULE_24
            end
            flb_pkg::FLB_PROT:
            begin
                next_q.idx = 6'h00;
                next_q.div_cnt = q.delay;
                next_q.pulse_cnt = q.clk_div;
                if (refuse)
                begin
                    // nothing reaches the array on this path
                    next_q.state = flb_pkg::FLB_DONE; // RULE_23
                    next_q.fail = 1'b1;
                    next_q.acc = `FLB_RET_OK; // RULE_03 RULE_13
                    next_q.skey = `FLB_RET_OK;
                    next_q.fkey = `FLB_RET_FAIL;
                end
                else if (q.func == `FLB_FN_PROGRAM)
                    next_q.state = flb_pkg::FLB_FETCH;
                else
                    next_q.state = flb_pkg::FLB_PULSE;
            end
            flb_pkg::FLB_FETCH:
            begin
                next_q.idx = q.idx + 6'h01;
                if (q.idx == `FLB_LAST_BYTE)
                    next_q.state = flb_pkg::FLB_PULSE; // RULE_01
            end
            flb_pkg::FLB_PULSE:
            begin
                // width = max(divider,1) ticks of delay+1 cycles
                next_q.div_cnt = tick ? q.delay : q.div_cnt - 8'h01;
                if (tick)
                    next_q.pulse_cnt = q.pulse_cnt - 8'h01; // RULE_08 RULE_14
                if (last_tick)
                begin
                    next_q.state = flb_pkg::FLB_DONE;
                    next_q.fail = 1'b0;
                    next_q.acc = `FLB_RET_OK;
                    next_q.fkey = `FLB_RET_OK;
                    next_q.skey = `FLB_RET_OK;
                end
            end
            flb_pkg::FLB_TABLE:
            begin
                next_q.tdata = fif.tdata; // RULE_19
                next_q.rev = fif.rev; // RULE_20
                next_q.state = flb_pkg::FLB_DONE;
                next_q.fail = 1'b0;
                next_q.acc = `FLB_RET_OK;
                next_q.fkey = `FLB_RET_OK;
                next_q.skey = `FLB_RET_OK;
            end
            flb_pkg::FLB_DONE: next_q.state = flb_pkg::FLB_IDLE;
            default: ;
        endcase
    end

    // one register for all state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else
            q <= next_q;
    end

    // helper counters that only the checks below read
    logic [6:0] wr_cnt;
    logic [15:0] plen;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_cnt <= 7'h00;
            plen <= 16'h0000;
        end
        else
        begin
            wr_cnt <= (q.state == flb_pkg::FLB_KEY) ? 7'h00 :
                wr_cnt + {6'h00, fif.wr};
            plen <= flash_pulse ? plen + 16'h0001 : 16'h0000;
        end
    end

    a_key_halt: assert property (@(posedge pclk) disable iff (!presetn)
        q.state == flb_pkg::FLB_KEY && !key_ok |=> cpu_halt [*3]) // RULE_22
        else $error("bad key did not halt");
    a_fail_codes: assert property (@(posedge pclk) disable iff (!presetn)
        q.state == flb_pkg::FLB_PROT && refuse |=> q.fkey == 8'h01 &&
        q.skey == 8'h00 && q.acc == 8'h00 ##1 !busy) // RULE_03
        else $error("refusal codes wrong");
    a_refuse_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        q.state == flb_pkg::FLB_PROT && refuse |=> !fif.wr &&
        !fif.blk_erase ##1 !fif.wr) // RULE_23
        else $error("refused block was touched");
    a_prog_bytes: assert property (@(posedge pclk) disable iff (!presetn)
        q.state == flb_pkg::FLB_DONE && !q.fail &&
        q.func == `FLB_FN_PROGRAM |-> wr_cnt == 7'd64) // RULE_01
        else $error("program did not move 64 bytes");
    // source address rebuilt from the write count, not from idx
    a_src_page: assert property (@(posedge pclk) disable iff (!presetn)
        fif.wr |-> sif.raddr_b ==
        {q.page[0], 8'(q.ptr + {1'b0, wr_cnt})}) // RULE_06
        else $error("source address wrong");
    a_pulse_len: assert property (@(posedge pclk) disable iff (!presetn)
        flash_pulse && last_tick |-> plen + 16'h0001 ==
        16'((q.clk_div == 8'h00 ? 8'h01 : q.clk_div) *
        ({8'h00, q.delay} + 16'h0001))) // RULE_08
        else $error("pulse width wrong");
    a_bulk_ext: assert property (@(posedge pclk) disable iff (!presetn)
        q.state == flb_pkg::FLB_KEY && q.func == `FLB_FN_BULK && !ext_prog
        |=> cpu_halt && !fif.bulk_erase) // RULE_18
        else $error("firmware bulk erase not stopped");
    // watch the mode itself, so a leak past the gate is caught too
    a_prot_lock: assert property (@(posedge pclk) disable iff (!presetn)
        !ext_prog && !fif.bulk_erase |=> fif.mode == $past(fif.mode) ||
        q.blk != $past(q.blk)) // RULE_04
        else $error("protection changed by firmware");
    a_pulse_first: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(q.state == flb_pkg::FLB_DONE) && !q.fail &&
        q.func != `FLB_FN_TABLE |-> $past(flash_pulse)) // RULE_24
        else $error("returned before pulse end");
    a_erase_blk: assert property (@(posedge pclk) disable iff (!presetn)
        fif.blk_erase |-> q.func == 8'h03 && !refuse) // RULE_13
        else $error("erase issued on protected block");
endmodule : flb_core

// [verification/flb_host_model.sv]
// apb master standing in for firmware or an external programmer
// assumes an apb slave on pclk that may add wait states
`timescale 1ns/1ps
module flb_host_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    logic [31:0] rdata;
    logic err;
    // idle bus from time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end
    // one transfer: setup, access held until pready at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data must not look like the last value
        pwdata <= ~d;
    endtask : xfer
endmodule : flb_host_model

// [verification/tb_top.sv]
// self-checking bench for the flash service core
// assumes flb_core holds its flash array and sram inside
`timescale 1ns/1ps
`include "flb_defs.svh"
module tb_top;
    logic pclk, presetn, ext_prog, pready, pslverr, psel, penable, pwrite;
    logic cpu_halt, busy, flash_pulse;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int err_count, n_checks, cyc, pcnt, bcnt, i;
    flb_core flb_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_prog(ext_prog), .cpu_halt(cpu_halt),
        .busy(busy), .flash_pulse(flash_pulse));
    flb_host_model flb_host_model_inst (.pclk(pclk), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));
    // 10 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // pulse and busy cycle counts, sampled mid-cycle where outputs settle
    always @(negedge pclk)
    begin
        cyc++;
        if (flash_pulse === 1'b1) pcnt++;
        if (busy === 1'b1) bcnt++;
        if (cyc == 40000)
        begin
            err_count++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        flb_host_model_inst.xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        flb_host_model_inst.xfer(1'b0, a, 32'h00000000);
        chk(flb_host_model_inst.rdata, exp);
    endtask : rd
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    // keys, block and code, then wait a bounded time for busy to fall
    task automatic call(input logic [7:0] code, input logic [7:0] blk,
        input logic [7:0] k1);
        wr(`FLB_OFF_FKEY, {24'h0, k1});
        wr(`FLB_OFF_SKEY, 32'h00000043);
        wr(`FLB_OFF_BLOCK, {24'h0, blk});
        pcnt = 0;
        bcnt = 0;
        wr(`FLB_OFF_FUNC, {16'h0, 8'h40, code});
        repeat (2) @(posedge pclk);
        for (i = 0; i < 3000 && busy === 1'b1; i++) @(posedge pclk);
    endtask : call
    task automatic t_program();
        wr(`FLB_OFF_CLKDIV, 32'h2);
        wr(`FLB_OFF_DELAY, 32'h3);
        wr(`FLB_OFF_PAGE, 32'h1);
        wr(`FLB_OFF_PTR, 32'hC0);
        // source pointer runs from C0h up to the last byte of the page, FFh
        for (int n = 0; n < 64; n++)
            wr(12'h800 + 12'(4 * (256 + ((192 + n) % 256))), n ^ 8'hA5);
        call(`FLB_FN_ERASE, 8'h02, `FLB_FKEY_VAL);
        chk(pcnt, 8);
        chk(bcnt, 11);
        rd(`FLB_OFF_FKEY, 32'h0);
        call(`FLB_FN_PROGRAM, 8'h02, `FLB_FKEY_VAL);
        chk(pcnt, 8);
        chk(bcnt, 75);
        for (int n = 0; n < 64; n++)
        begin
            wr(`FLB_OFF_ROMADDR, 128 + n);
            rd(`FLB_OFF_ROMDATA, n ^ 8'hA5);
        end
    endtask : t_program
    task automatic t_protect();
        ext_prog <= 1'b1;
        wr(`FLB_OFF_PROT, 32'h305);
        wr(`FLB_OFF_PROT, 32'h206);
        ext_prog <= 1'b0;
        wr(`FLB_OFF_PROT, 32'h005);
        call(`FLB_FN_ERASE, 8'h05, `FLB_FKEY_VAL);
        rd(`FLB_OFF_PROT, 32'h3);
        rd(`FLB_OFF_FKEY, 32'h1);
        rd(`FLB_OFF_SKEY, 32'h0);
        rd(`FLB_OFF_ACC, 32'h0);
        rd(`FLB_OFF_STATUS, 32'h8);
        chk(pcnt, 0);
        call(`FLB_FN_PROGRAM, 8'h05, `FLB_FKEY_VAL);
        rd(`FLB_OFF_FKEY, 32'h1);
        rd(`FLB_OFF_SKEY, 32'h0);
        chk(pcnt, 0);
        // mode 10b stops only the programmer; firmware may erase
        call(`FLB_FN_ERASE, 8'h06, `FLB_FKEY_VAL);
        rd(`FLB_OFF_FKEY, 32'h0);
        chk(pcnt, 8);
        ext_prog <= 1'b1;
        call(`FLB_FN_ERASE, 8'h06, `FLB_FKEY_VAL);
        rd(`FLB_OFF_FKEY, 32'h1);
        ext_prog <= 1'b0;
        // a block number above 7Fh is refused like protection
        call(`FLB_FN_ERASE, 8'h80, `FLB_FKEY_VAL);
        rd(`FLB_OFF_FKEY, 32'h1);
        chk(pcnt, 0);
    endtask : t_protect
    task automatic t_table();
        wr(`FLB_OFF_TBLSEL, 32'h3);
        call(`FLB_FN_TABLE, 8'h00, `FLB_FKEY_VAL);
        rd(`FLB_OFF_TDHI, 32'h01000000);
        rd(`FLB_OFF_REV, 32'h5A);
        flb_host_model_inst.xfer(1'b0, 12'h044, 32'h0);
        chk(flb_host_model_inst.err, 1'b1);
    endtask : t_table
    task automatic t_bulk();
        ext_prog <= 1'b1;
        call(`FLB_FN_BULK, 8'h05, `FLB_FKEY_VAL);
        rd(`FLB_OFF_PROT, 32'h0);
        ext_prog <= 1'b0;
        call(`FLB_FN_BULK, 8'h05, `FLB_FKEY_VAL);
        chk(cpu_halt, 1'b1);
        do_reset();
        chk(cpu_halt, 1'b0);
        call(`FLB_FN_ERASE, 8'h05, 8'h3B);
        chk(cpu_halt, 1'b1);
    endtask : t_bulk
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // main sequence
    initial
    begin
        presetn = 1'b0;
        ext_prog = 1'b0;
        do_reset();
        rd(`FLB_OFF_STATUS, 32'h0);
        t_program();
        t_protect();
        t_table();
        t_bulk();
        conclude();
    end
endmodule : tb_top
